// ==== design/dpa_map.svh ====
// constants for the dual alternate-function port block: bit positions and reset values
// assumes inclusion by bare name from the package and the port modules
`ifndef DPA_MAP_SVH
`define DPA_MAP_SVH
`define DPA_WIDTH 8
`define DPA_LATCH_RST 8'hff
`define DPA_P3_RXD 0
`define DPA_P3_TXD 1
`define DPA_P3_IRQ0 2
`define DPA_P3_IRQ1 3
`define DPA_P3_CNT0 4
`define DPA_P3_CNT1 5
`define DPA_P3_WRS 6
`define DPA_P3_RDS 7
`define DPA_P1_CC_LO 0
`define DPA_P1_CC_HI 3
`define DPA_P1_IRQ2 4
`define DPA_P1_RELOAD 5
`define DPA_P1_SYSTEM_CLOCK_PIN 6
`define DPA_P1_CNT2 7
`endif

// ==== design/dpa_pin_cell.sv ====
// one quasi-bidirectional port of eight pins: latch, pull-down drive, input sample
// assumes pad inputs synchronous to ref_clk; the board pull-up sets released pins high
`default_nettype none
`include "dpa_map.svh"
module dpa_pin_cell (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic latch_we,
  input wire logic [7:0] latch_wdata,
  input wire dpa_pkg::dpa_alt_t alt,
  input wire logic [7:0] pad_in,
  output logic [7:0] latch_q,
  output logic [7:0] pin_q,
  output var dpa_pkg::dpa_pad_t pad
);
  // ==========================================
  // latch
  // all ones at reset so pins start released
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_q <= `DPA_LATCH_RST;
    end else if (latch_we) begin
      latch_q <= latch_wdata;
    end
  end
  // ==========================================
  // per-pin drive: low when latch or alternate low (alternate alone when forced), released otherwise
  genvar i;
  generate
    for (i = 0; i < `DPA_WIDTH; i++) begin : g_pin
      logic drive_low;
      // a forced alternate (compare) ignores the latch
      assign drive_low = alt.force_en[i] ? !alt.alt_out[i] : (!latch_q[i] || !alt.alt_out[i]);
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          pad.pad_out[i] <= 1'b0;
          pad.pad_oe[i] <= 1'b0;
          pin_q[i] <= 1'b1;
        end else begin
          pad.pad_out[i] <= 1'b0;
          pad.pad_oe[i] <= drive_low;
          pin_q[i] <= pad_in[i] && !drive_low;
        end
      end
    end
  endgenerate
  // ==========================================
  // checks
  led_zero_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!latch_q[0] && !alt.force_en[0]) |=> pad.pad_oe[0]) else $error("pin not pulled low with latch zero");
  released_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (latch_q[1] && alt.alt_out[1]) |=> !pad.pad_oe[1]) else $error("pin driven while released");
endmodule
`default_nettype wire

// ==== design/dpa_pkg.sv ====
// types shared by the dual alternate-function port block
// assumes dpa_map.svh is on the include path
`default_nettype none
`include "dpa_map.svh"
package dpa_pkg;
  // alternate outputs from the peripherals for one port, active level as on the pin
  typedef struct packed {
    logic [`DPA_WIDTH-1:0] alt_out;
    logic [`DPA_WIDTH-1:0] force_en;
  } dpa_alt_t;
  // pin side of one port: pull-down drive level and its enable
  typedef struct packed {
    logic [`DPA_WIDTH-1:0] pad_out;
    logic [`DPA_WIDTH-1:0] pad_oe;
  } dpa_pad_t;
endpackage
`default_nettype wire

// ==== design/dpa_ports.sv ====
// two quasi-bidirectional ports with their alternate functions
// assumes peripherals on the core side and pull-ups plus memory on the board side
`default_nettype none
`include "dpa_map.svh"
// What this block does
// - port_three has eight pins with pull-ups; latch one lets a pin be input.
// - port_one has eight pins with pull-ups; latch one lets a pin be input.
// - port_three alternates work only while the pin latch holds one.
// - port_one alternates need latch one, except compare outputs.
// - port_three bit 0 carries serial receive, or sync data line.
// - port_three bit 1 carries serial transmit, or sync shift clock.
// - port_three bits 2 and 3 are external interrupts and timer gates.
// - port_three bits 4 and 5 are counter inputs for timers 0 and 1.
// - port_three bit 6 outputs the external memory write strobe.
// - port_three bit 7 outputs the external memory read strobe.
// - port_one carries low address byte during program verification.
// - port_one bits 0-3 combine interrupt, compare output and capture input.
// - port_one bit 4 is external interrupt two.
// - port_one bit 5 is the timer 2 reload trigger.
// - port_one bit 6 can output the system clock.
// - port_one bit 7 is counter input for timer 2.
module dpa_ports (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic p3_we,
  input wire logic [7:0] p3_wdata,
  input wire logic p1_we,
  input wire logic [7:0] p1_wdata,
  input wire logic serial_sync_mode,
  input wire logic serial_data_out,
  input wire logic serial_transmit_out,
  input wire logic store_strobe_n,
  input wire logic load_strobe_n,
  input wire logic [3:0] compare_en,
  input wire logic [3:0] compare_out,
  input wire logic system_clock_pin_en,
  input wire logic system_clock_pin_level,
  input wire logic verify_mode,
  input wire logic [7:0] verify_addr_lo,
  input wire logic [7:0] port_three_in,
  input wire logic [7:0] port_one_in,
  output logic [7:0] port_three_out,
  output logic [7:0] port_three_oe,
  output logic [7:0] port_one_out,
  output logic [7:0] port_one_oe,
  output logic [7:0] port_three_latch,
  output logic [7:0] port_one_latch,
  output logic [7:0] port_three_pins,
  output logic [7:0] port_one_pins,
  output logic serial_receive_pin,
  output logic ext_irq_zero,
  output logic ext_irq_one,
  output logic counter_zero_input,
  output logic counter_one_input,
  output logic [3:0] ext_irq_three_six,
  output logic [3:0] capture_in,
  output logic ext_irq_two,
  output logic reload_trigger_input,
  output logic counter_two_input
);
  // ==========================================
  // alternate output assembly, idle high means released
  dpa_pkg::dpa_alt_t p3_alt;
  dpa_pkg::dpa_alt_t p1_alt;
  dpa_pkg::dpa_pad_t p3_pad;
  dpa_pkg::dpa_pad_t p1_pad;
  logic [7:0] p1_wr_mux;
  logic p1_we_mux;
  always_comb begin
    p3_alt.alt_out = 8'hff;
    p3_alt.force_en = 8'h00;
    // receive pin is driven only as sync data line
    p3_alt.alt_out[`DPA_P3_RXD] = serial_sync_mode ? serial_data_out : 1'b1;
    p3_alt.alt_out[`DPA_P3_TXD] = serial_transmit_out;
    p3_alt.alt_out[`DPA_P3_WRS] = store_strobe_n;
    p3_alt.alt_out[`DPA_P3_RDS] = load_strobe_n;
    p1_alt.alt_out = 8'hff;
    p1_alt.force_en = 8'h00;
    // compare outputs bypass the latch
    p1_alt.alt_out[`DPA_P1_CC_HI:`DPA_P1_CC_LO] = ~compare_en | compare_out;
    p1_alt.force_en[`DPA_P1_CC_HI:`DPA_P1_CC_LO] = compare_en;
    // clock copy only toggles as fast as the divider in front of it
    p1_alt.alt_out[`DPA_P1_SYSTEM_CLOCK_PIN] = system_clock_pin_en ? system_clock_pin_level : 1'b1;
  end
  // verification loads the latch with the address byte each cycle
  assign p1_we_mux = p1_we || verify_mode;
  assign p1_wr_mux = verify_mode ? verify_addr_lo : p1_wdata;
  // ==========================================
  // the two ports
  dpa_pin_cell u_p3 (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .latch_we(p3_we),
    .latch_wdata(p3_wdata),
    .alt(p3_alt),
    .pad_in(port_three_in),
    .latch_q(port_three_latch),
    .pin_q(port_three_pins),
    .pad(p3_pad)
  );
  dpa_pin_cell u_p1 (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .latch_we(p1_we_mux),
    .latch_wdata(p1_wr_mux),
    .alt(p1_alt),
    .pad_in(port_one_in),
    .latch_q(port_one_latch),
    .pin_q(port_one_pins),
    .pad(p1_pad)
  );
  assign port_three_out = p3_pad.pad_out;
  assign port_three_oe = p3_pad.pad_oe;
  assign port_one_out = p1_pad.pad_out;
  assign port_one_oe = p1_pad.pad_oe;
  // ==========================================
  // alternate inputs, taken from sampled pin levels (already registered)
  assign serial_receive_pin = port_three_pins[`DPA_P3_RXD];
  assign ext_irq_zero = port_three_pins[`DPA_P3_IRQ0];
  assign ext_irq_one = port_three_pins[`DPA_P3_IRQ1];
  assign counter_zero_input = port_three_pins[`DPA_P3_CNT0];
  assign counter_one_input = port_three_pins[`DPA_P3_CNT1];
  assign ext_irq_three_six = port_one_pins[`DPA_P1_CC_HI:`DPA_P1_CC_LO];
  assign capture_in = port_one_pins[`DPA_P1_CC_HI:`DPA_P1_CC_LO];
  assign ext_irq_two = port_one_pins[`DPA_P1_IRQ2];
  assign reload_trigger_input = port_one_pins[`DPA_P1_RELOAD];
  assign counter_two_input = port_one_pins[`DPA_P1_CNT2];
  // ==========================================
  // checks
  store_strobe_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!store_strobe_n) |=> port_three_oe[`DPA_P3_WRS]) else $error("store strobe not on pin");
  load_strobe_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!load_strobe_n) |=> port_three_oe[`DPA_P3_RDS]) else $error("load strobe not on pin");
  compare_force_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (compare_en[0] && compare_out[0]) |=> !port_one_oe[0]) else $error("compare high blocked by latch");
  verify_addr_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    verify_mode |=> port_one_latch == $past(verify_addr_lo)) else $error("verify address not latched");
  tx_drive_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!serial_transmit_out) |=> port_three_oe[`DPA_P3_TXD]) else $error("transmit low not driven");
  clk_out_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (system_clock_pin_en && !system_clock_pin_level) |=> port_one_oe[`DPA_P1_SYSTEM_CLOCK_PIN]) else $error("clock copy low not driven");
  // a strobe cannot release a pin whose latch holds zero
  strobe_latch_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!port_three_latch[`DPA_P3_WRS]) |=> port_three_oe[`DPA_P3_WRS]) else $error("zero latch not driven");
  // pads only ever sink, never source a high
  sink_only_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (port_three_out == 8'h00) && (port_one_out == 8'h00)) else $error("pad driven high");
endmodule
`default_nettype wire

// ==== verification/dpa_board.sv ====
// board model: pull-ups on both ports plus sources that may pull pins low
// assumes oe high means the device sinks the pin
`default_nettype none
module dpa_board (
  input wire logic [7:0] p3_oe,
  input wire logic [7:0] p1_oe,
  input wire logic [7:0] p3_ext_low,
  input wire logic [7:0] p1_ext_low,
  output logic [7:0] p3_pad,
  output logic [7:0] p1_pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // pad resolution
  // wired-and: any sink wins, otherwise the pull-up holds the pin high
  assign p3_pad = ~(p3_oe | p3_ext_low);
  assign p1_pad = ~(p1_oe | p1_ext_low);
endmodule
`default_nettype wire

// ==== verification/dual_port_alt_function_pins_bench.sv ====
// directed bench for the two alternate-function ports
// assumes dpa_ports as top and dpa_board as the pin side
`default_nettype none
module dual_port_alt_function_pins_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, arst_n, p3_we, p1_we, sync_m, sdo, sto, st_n, ld_n, ck_en, ck_lv, vm;
  logic [7:0] p3_wd, p1_wd, va, x3, x1, i3, i1, o3, o1, e3, e1, l3, l1, q3, q1, i36, cap;
  logic [3:0] c_en, c_out;
  logic rx, q0, q1b, c0, c1, q2, rl, c2;
  int n_mismatch = 0;
  int checks = 0;
  // ====================
  // instances
  dpa_ports uut (.ref_clk(ref_clk), .arst_n(arst_n), .p3_we(p3_we), .p3_wdata(p3_wd), .p1_we(p1_we),
    .p1_wdata(p1_wd), .serial_sync_mode(sync_m), .serial_data_out(sdo), .serial_transmit_out(sto),
    .store_strobe_n(st_n), .load_strobe_n(ld_n), .compare_en(c_en), .compare_out(c_out),
    .system_clock_pin_en(ck_en), .system_clock_pin_level(ck_lv), .verify_mode(vm), .verify_addr_lo(va),
    .port_three_in(i3), .port_one_in(i1), .port_three_out(o3), .port_three_oe(e3),
    .port_one_out(o1), .port_one_oe(e1), .port_three_latch(l3), .port_one_latch(l1),
    .port_three_pins(q3), .port_one_pins(q1), .serial_receive_pin(rx), .ext_irq_zero(q0),
    .ext_irq_one(q1b), .counter_zero_input(c0), .counter_one_input(c1), .ext_irq_three_six(i36[3:0]),
    .capture_in(cap[3:0]), .ext_irq_two(q2), .reload_trigger_input(rl), .counter_two_input(c2));
  dpa_board brd (.p3_oe(e3), .p1_oe(e1), .p3_ext_low(x3), .p1_ext_low(x1), .p3_pad(i3), .p1_pad(i1));
  assign i36[7:4] = 4'h0;
  assign cap[7:4] = 4'h0;
  // ====================
  // helpers
  // clock at 40 MHz
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // three edges cover latch plus oe plus pin sample; #1 lets the last edge settle
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] b);
    @(posedge ref_clk);
    p3_we <= 1'b1; p3_wd <= a; p1_we <= 1'b1; p1_wd <= b;
    @(posedge ref_clk);
    p3_we <= 1'b0; p1_we <= 1'b0;
    settle();
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ====================
  // scenarios
  task automatic t_latch;
    wr(8'h5a, 8'ha5);
    chk(l3, 8'h5a);
    chk(e3, 8'ha5);
    chk(q1, 8'ha5);
    chk(o3 | o1, 8'h00);
    $display("test latch done");
  endtask
  task automatic t_alt3;
    wr(8'hff, 8'hff);
    @(posedge ref_clk);
    sto <= 1'b0; st_n <= 1'b0; ld_n <= 1'b0; sync_m <= 1'b1; sdo <= 1'b0;
    settle();
    chk(e3, 8'hc3);
    @(posedge ref_clk);
    sto <= 1'b1; st_n <= 1'b1; ld_n <= 1'b1; sync_m <= 1'b0;
    wr(8'h3c, 8'hff);
    chk(e3, 8'hc3);
    $display("test alt3 done");
  endtask
  task automatic t_inputs;
    wr(8'hff, 8'hff);
    @(posedge ref_clk);
    x3 <= 8'h55; x1 <= 8'h3c;
    settle();
    chk({3'h0, c1, c0, q1b, q0, rx}, 8'h14);
    chk({i36[3:0], cap[3:0]}, 8'h33);
    chk({5'h0, c2, rl, q2}, 8'h04);
    @(posedge ref_clk);
    x3 <= 8'h00; x1 <= 8'h00;
    $display("test inputs done");
  endtask
  task automatic t_cmp_clk;
    wr(8'hff, 8'h00);
    @(posedge ref_clk);
    c_en <= 4'hf; c_out <= 4'h5;
    settle();
    chk(e1, 8'hfa);
    @(posedge ref_clk);
    c_en <= 4'h0;
    wr(8'hff, 8'hff);
    @(posedge ref_clk);
    ck_en <= 1'b1; ck_lv <= 1'b0;
    settle();
    chk(e1, 8'h40);
    @(posedge ref_clk);
    ck_lv <= 1'b1;
    settle();
    chk(e1, 8'h00);
    @(posedge ref_clk);
    ck_en <= 1'b0;
    $display("test compare clock done");
  endtask
  task automatic t_verify;
    @(posedge ref_clk);
    vm <= 1'b1; va <= 8'h3c; p1_we <= 1'b1; p1_wd <= 8'h00;
    settle();
    chk(l1, 8'h3c);
    @(posedge ref_clk);
    vm <= 1'b0; p1_we <= 1'b0;
    $display("test verify done");
  endtask
  // ====================
  // main sequence
  initial begin
    arst_n = 1'b0; p3_we = 1'b0; p1_we = 1'b0; p3_wd = 8'h00; p1_wd = 8'h00; sync_m = 1'b0;
    sdo = 1'b1; sto = 1'b1; st_n = 1'b1; ld_n = 1'b1; c_en = 4'h0; c_out = 4'h0; ck_en = 1'b0;
    ck_lv = 1'b0; vm = 1'b0; va = 8'h00; x3 = 8'h00; x1 = 8'h00;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    settle();
    chk(l3 & l1, 8'hff);
    chk(e3 | e1, 8'h00);
    chk(q3 & q1, 8'hff);
    $display("test reset done");
    t_latch();
    t_alt3();
    t_inputs();
    t_cmp_clk();
    t_verify();
    print_verdict();
  end
endmodule
`default_nettype wire
